// file: verilog/pll_div_consts.vh
// Register offsets, field positions and reset values of the PLL divider configuration bank
`ifndef PLL_DIV_CONSTS_VH
`define PLL_DIV_CONSTS_VH
`define ADDR_FB_PHASE_HIGH 4'h0
`define ADDR_FB_LOW 4'h1
`define ADDR_FB2_LOW 4'h2
`define ADDR_FB_BYP_MSB 4'h3
`define ADDR_REF_PHASE_HIGH 4'h4
`define ADDR_REF_LOW 4'h5
`define ADDR_SS_FB_MSB 4'h8
`define ADDR_SS_FB_LOW 4'h9
`define ADDR_FS_BYPASS 4'ha
`define ADDR_DBL_PREDIV 4'hc
`define RST_FB_RATIO 12'hc00
`define RST_REF_RATIO 12'hc00
`define RST_FB2_RATIO 9'h060
`define RST_SS_FB_RATIO 9'h018
`define RST_PHASE 3'h0
`define RST_PREDIV 6'h00
`define RST_BIT 1'h0
`define PREDIV_BYPASS 6'h00
`define RST_ENABLE 1'h1
`define RD_IDLE 8'h00
`define FLD_PHASE 7:5
`define FLD_PD 4
`define FLD_NIBBLE 3:0
`define FLD_TOP 7
`define FLD_BIT0 0
`define FLD_PREDIV 5:0
`define RATIO_HIGH 11:8
`define RATIO_LOW 7:0
`define RATIO9_MSB 8
`endif

// file: verilog/pll_divider_config_regs.v
// Divider configuration register bank of a two-stage clock-synthesis PLL
`timescale 1ns/1ps
`include "pll_div_consts.vh"
module pll_divider_config_regs (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Register port
    input wire [3:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // First-stage dividers
    output reg [11:0] feedback_div_ratio,
    output reg [2:0] feedback_phase_sel,
    output reg [8:0] second_feedback_div_ratio,
    output reg second_feedback_div_powerdown,
    output reg second_feedback_div_enable,
    output reg feedback_bypass_sel,
    output reg use_product_feedback,
    output reg [11:0] reference_div_ratio,
    output reg [2:0] reference_phase_sel,
    // Second stage
    output reg [8:0] second_stage_feedback_ratio,
    output reg first_stage_bypass_sel,
    output reg first_stage_enable,
    output reg doubler_sel,
    output reg [5:0] second_stage_prediv_ratio,
    output reg prediv_active
);

    reg [7:0] rdata_d;

    // Read images; reserved bits read zero
    wire [7:0] fb_phase_high_img;
    wire [7:0] fb_low_img;
    wire [7:0] fb2_low_img;
    wire [7:0] fb_byp_msb_img;
    wire [7:0] ref_phase_high_img;
    wire [7:0] ref_low_img;
    wire [7:0] ss_fb_msb_img;
    wire [7:0] ss_fb_low_img;
    wire [7:0] fs_bypass_img;
    wire [7:0] dbl_prediv_img;

    // Next values of the decoded controls
    wire second_feedback_div_enable_d;
    wire use_product_feedback_d;
    wire first_stage_enable_d;
    wire prediv_active_d;

    assign fb_phase_high_img = {feedback_phase_sel, second_feedback_div_powerdown, feedback_div_ratio[`RATIO_HIGH]};
    assign fb_low_img = feedback_div_ratio[`RATIO_LOW];
    assign fb2_low_img = second_feedback_div_ratio[`RATIO_LOW];
    assign fb_byp_msb_img = {second_feedback_div_ratio[`RATIO9_MSB], 6'h00, feedback_bypass_sel};
    assign ref_phase_high_img = {reference_phase_sel, 1'h0, reference_div_ratio[`RATIO_HIGH]};
    assign ref_low_img = reference_div_ratio[`RATIO_LOW];
    assign ss_fb_msb_img = {7'h00, second_stage_feedback_ratio[`RATIO9_MSB]};
    assign ss_fb_low_img = second_stage_feedback_ratio[`RATIO_LOW];
    assign fs_bypass_img = {7'h00, first_stage_bypass_sel};
    assign dbl_prediv_img = {doubler_sel, 1'h0, second_stage_prediv_ratio};

    assign second_feedback_div_enable_d = ~second_feedback_div_powerdown;
    assign use_product_feedback_d = feedback_bypass_sel & ~second_feedback_div_powerdown;
    assign first_stage_enable_d = ~first_stage_bypass_sel;
    assign prediv_active_d = ~doubler_sel & (second_stage_prediv_ratio != `PREDIV_BYPASS);

    // Write decode, reset defaults
    always @(posedge clk) begin
        if (!rstn) begin
            feedback_div_ratio <= `RST_FB_RATIO;
            feedback_phase_sel <= `RST_PHASE;
            reference_phase_sel <= `RST_PHASE;
            second_feedback_div_ratio <= `RST_FB2_RATIO;
            second_feedback_div_powerdown <= `RST_BIT;
            feedback_bypass_sel <= `RST_BIT;
            reference_div_ratio <= `RST_REF_RATIO;
            second_stage_feedback_ratio <= `RST_SS_FB_RATIO;
            first_stage_bypass_sel <= `RST_BIT;
            doubler_sel <= `RST_BIT;
            second_stage_prediv_ratio <= `RST_PREDIV;
        end else if (reg_wr) begin
            // Range limits are not enforced; software keeps ratios legal
            // register placement
            case (reg_addr)
                `ADDR_FB_PHASE_HIGH: begin
                    feedback_phase_sel <= reg_wdata[`FLD_PHASE];
                    second_feedback_div_powerdown <= reg_wdata[`FLD_PD];
                    feedback_div_ratio[`RATIO_HIGH] <= reg_wdata[`FLD_NIBBLE];
                end
                `ADDR_FB_LOW: begin
                    feedback_div_ratio[`RATIO_LOW] <= reg_wdata;
                end
                `ADDR_FB2_LOW: begin
                    second_feedback_div_ratio[`RATIO_LOW] <= reg_wdata;
                end
                `ADDR_FB_BYP_MSB: begin
                    second_feedback_div_ratio[`RATIO9_MSB] <= reg_wdata[`FLD_TOP];
                    feedback_bypass_sel <= reg_wdata[`FLD_BIT0];
                end
                `ADDR_REF_PHASE_HIGH: begin
                    reference_phase_sel <= reg_wdata[`FLD_PHASE];
                    reference_div_ratio[`RATIO_HIGH] <= reg_wdata[`FLD_NIBBLE];
                end
                `ADDR_REF_LOW: begin
                    reference_div_ratio[`RATIO_LOW] <= reg_wdata;
                end
                `ADDR_SS_FB_MSB: begin
                    second_stage_feedback_ratio[`RATIO9_MSB] <= reg_wdata[`FLD_BIT0];
                end
                `ADDR_SS_FB_LOW: begin
                    second_stage_feedback_ratio[`RATIO_LOW] <= reg_wdata;
                end
                `ADDR_FS_BYPASS: begin
                    first_stage_bypass_sel <= reg_wdata[`FLD_BIT0];
                end
                `ADDR_DBL_PREDIV: begin
                    doubler_sel <= reg_wdata[`FLD_TOP];
                    second_stage_prediv_ratio <= reg_wdata[`FLD_PREDIV];
                end
                // Unmapped addresses are dropped
                default: begin
                end
            endcase
        end
    end

    // Decoded controls, registered one cycle after the fields
    // One cycle of latency keeps the analog controls free of decode glitches
    always @(posedge clk) begin
        if (!rstn) begin
            second_feedback_div_enable <= `RST_ENABLE;
            use_product_feedback <= `RST_BIT;
            first_stage_enable <= `RST_ENABLE;
            prediv_active <= `RST_BIT;
        end else begin
            second_feedback_div_enable <= second_feedback_div_enable_d;
            use_product_feedback <= use_product_feedback_d;
            first_stage_enable <= first_stage_enable_d;
            prediv_active <= prediv_active_d;
        end
    end

    // Readback mux; unmapped addresses read zero
    always @* begin
        rdata_d = `RD_IDLE;
        case (reg_addr)
            `ADDR_FB_PHASE_HIGH: begin
                rdata_d = fb_phase_high_img;
            end
            `ADDR_FB_LOW: begin
                rdata_d = fb_low_img;
            end
            `ADDR_FB2_LOW: begin
                rdata_d = fb2_low_img;
            end
            `ADDR_FB_BYP_MSB: begin
                rdata_d = fb_byp_msb_img;
            end
            `ADDR_REF_PHASE_HIGH: begin
                rdata_d = ref_phase_high_img;
            end
            `ADDR_REF_LOW: begin
                rdata_d = ref_low_img;
            end
            `ADDR_SS_FB_MSB: begin
                rdata_d = ss_fb_msb_img;
            end
            `ADDR_SS_FB_LOW: begin
                rdata_d = ss_fb_low_img;
            end
            `ADDR_FS_BYPASS: begin
                rdata_d = fs_bypass_img;
            end
            `ADDR_DBL_PREDIV: begin
                rdata_d = dbl_prediv_img;
            end
            default: begin
                rdata_d = `RD_IDLE;
            end
        endcase
    end

    // Registered read keeps the output glitch free
    always @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= `RD_IDLE;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

endmodule

// file: tb/pll_cfg_sva.sv
// Port checker for the PLL divider configuration bank
`timescale 1ns/1ps
module pll_cfg_sva (
    // Clock, reset and register port
    input wire clk, input wire rstn, input wire [3:0] reg_addr, input wire reg_wr, input wire [7:0] reg_wdata,
    // Fields and decodes
    input wire [11:0] feedback_div_ratio, input wire [2:0] feedback_phase_sel,
    input wire [8:0] second_feedback_div_ratio, input wire second_feedback_div_powerdown,
    input wire second_feedback_div_enable, input wire feedback_bypass_sel, input wire use_product_feedback,
    input wire first_stage_bypass_sel, input wire first_stage_enable, input wire doubler_sel,
    input wire [5:0] second_stage_prediv_ratio, input wire prediv_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    fb_high_write_a: assert property (reg_wr && reg_addr == 4'h0 |=>
        {feedback_phase_sel, second_feedback_div_powerdown, feedback_div_ratio[11:8]} == $past(reg_wdata))
        else $error("byte 0x0 not stored");
    fb_low_write_a: assert property (reg_wr && reg_addr == 4'h1 |=>
        feedback_div_ratio[7:0] == $past(reg_wdata)) else $error("byte 0x1 not stored");
    fb2_low_write_a: assert property (reg_wr && reg_addr == 4'h2 |=>
        second_feedback_div_ratio[7:0] == $past(reg_wdata)) else $error("byte 0x2 not stored");
    fb2_msb_write_a: assert property (reg_wr && reg_addr == 4'h3 |=>
        {second_feedback_div_ratio[8], feedback_bypass_sel} == {$past(reg_wdata[7]), $past(reg_wdata[0])})
        else $error("byte 0x3 not stored");
    pd_enable_a: assert property (second_feedback_div_enable == !$past(second_feedback_div_powerdown))
        else $error("divider enable wrong");
    product_path_a: assert property (use_product_feedback ==
        $past(feedback_bypass_sel && !second_feedback_div_powerdown)) else $error("product path wrong");
    fs_enable_a: assert property (first_stage_enable == !$past(first_stage_bypass_sel))
        else $error("first stage enable wrong");
    prediv_use_a: assert property (prediv_active ==
        $past(!doubler_sel && second_stage_prediv_ratio != 6'h00)) else $error("pre-divider use wrong");
    dbl_prediv_write_a: assert property (reg_wr && reg_addr == 4'hc |=>
        {doubler_sel, second_stage_prediv_ratio} == {$past(reg_wdata[7]), $past(reg_wdata[5:0])})
        else $error("byte 0xc not stored");
    fs_bypass_write_a: assert property (reg_wr && reg_addr == 4'ha |=>
        first_stage_bypass_sel == $past(reg_wdata[0])) else $error("byte 0xa not stored");
    fields_hold_a: assert property (!reg_wr |=> $stable(feedback_div_ratio) && $stable(second_feedback_div_ratio))
        else $error("field changed without write");
    cover property (reg_wr && reg_addr == 4'hc);
    cover property (use_product_feedback);
    cover property (prediv_active);
endmodule
bind pll_divider_config_regs pll_cfg_sva u_pll_cfg_sva (.clk, .rstn, .reg_addr, .reg_wr, .reg_wdata,
    .feedback_div_ratio, .feedback_phase_sel, .second_feedback_div_ratio, .second_feedback_div_powerdown,
    .second_feedback_div_enable, .feedback_bypass_sel, .use_product_feedback, .first_stage_bypass_sel,
    .first_stage_enable, .doubler_sel, .second_stage_prediv_ratio, .prediv_active);

// file: tb/pll_divider_config_regs_bench.sv
// Self-checking bench for the PLL divider configuration bank
`timescale 1ns/1ps
module pll_divider_config_regs_bench;
    reg clk = 1'h0, rstn = 1'h0, reg_wr = 1'h0;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    wire [7:0] reg_rdata;
    wire [11:0] feedback_div_ratio, reference_div_ratio;
    wire [8:0] second_feedback_div_ratio, second_stage_feedback_ratio;
    wire [2:0] feedback_phase_sel, reference_phase_sel;
    wire [5:0] second_stage_prediv_ratio;
    wire second_feedback_div_powerdown, second_feedback_div_enable, feedback_bypass_sel, use_product_feedback;
    wire first_stage_bypass_sel, first_stage_enable, doubler_sel, prediv_active;
    wire [3:0] decodes;
    assign decodes = {second_feedback_div_enable, use_product_feedback, first_stage_enable, prediv_active};
    integer failures = 0, total_checks = 0, i;
    // Mapped addresses, then two unmapped ones that must read 0
    localparam [47:0] ADDRS = 48'h0123_4589_ac6b;
    localparam [95:0] RST = 96'h0c00_6000_0c00_0018_0000_0000;
    localparam [95:0] ONES = 96'hffff_ff81_efff_01ff_01bf_0000;
    pll_divider_config_regs u_pll_divider_config_regs (.clk, .rstn, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
        .feedback_div_ratio, .feedback_phase_sel, .second_feedback_div_ratio, .second_feedback_div_powerdown,
        .second_feedback_div_enable, .feedback_bypass_sel, .use_product_feedback, .reference_div_ratio,
        .reference_phase_sel, .second_stage_feedback_ratio, .first_stage_bypass_sel, .first_stage_enable,
        .doubler_sel, .second_stage_prediv_ratio, .prediv_active);
    always #50 clk = ~clk;
    task check(input [15:0] exp, input [15:0] got, input [8*10:1] what);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("unexpected %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // Write strobe stays high across calls so writes run back to back
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'h1;
        end
    endtask
    // Read data shows one edge after the address
    task read_all(input [95:0] exp);
        for (i = 0; i < 12; i = i + 1) begin
            @(posedge clk);
            reg_addr <= ADDRS[47-4*i -: 4];
            @(posedge clk);
            #1 check(exp[95-8*i -: 8], reg_rdata, "reg_rdata");
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d failures %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        #100000 failures = failures + 1;
        finish_test;
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'h1;
        read_all(RST);
        check(16'ha, decodes, "decodes");
        $display("reset values done");
        for (i = 0; i < 12; i = i + 1) wr(ADDRS[47-4*i -: 4], 8'hff);
        @(posedge clk) reg_wr <= 1'h0;
        read_all(ONES);
        check(16'h7fff, {reference_phase_sel, reference_div_ratio}, "ref");
        check(16'h7fff, {feedback_phase_sel, feedback_div_ratio}, "feedback");
        check(16'h03ff, {second_feedback_div_ratio, feedback_bypass_sel}, "fb2 field");
        check(16'h0001, second_feedback_div_powerdown, "powerdown");
        check(16'h00ff, {doubler_sel, first_stage_bypass_sel, second_stage_prediv_ratio}, "stage sel");
        check(16'h01ff, second_stage_feedback_ratio, "ss ratio");
        check(16'h0, decodes, "decodes");
        $display("full write done");
        wr(4'h0, 8'he5);
        wr(4'hc, 8'h3f);
        @(posedge clk) reg_wr <= 1'h0;
        @(posedge clk) #1 check(16'h75ff, {feedback_phase_sel, feedback_div_ratio}, "feedback");
        check(16'hd, decodes, "decodes");
        $display("decode test done");
        @(posedge clk) rstn <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        read_all(RST);
        check(16'ha, decodes, "decodes");
        $display("mid-run reset done");
        finish_test;
    end
endmodule
